//--- src/fbl_pkg.sv
package fbl_pkg;
    // timing at the 100 MHz system clock, one state per clock
    localparam int CLK_MHZ = 100;
    localparam int READY_STATES = 100;
    localparam int READY_CYC = (READY_STATES < 1) ? 1 : READY_STATES;
    localparam int LEAVE_STATES = 20;
    localparam int STRAP_STATES = 4;
    // low period of a zero byte: start bit plus eight data bits
    localparam int LOW_BITS = 9;
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = 10;
    // handshake bytes
    localparam logic [7:0] BYTE_SYNC = 8'h00;
    localparam logic [7:0] BYTE_GO = 8'h55;
    localparam logic [7:0] BYTE_OK = 8'hAA;
    localparam logic [7:0] BYTE_FAIL = 8'hFF;
    // control program window in on-chip ram
    localparam logic [15:0] RAM_LO = 16'hF780;
    localparam logic [15:0] RAM_HI = 16'hFEFF;
    // reset values and buffer depth
    localparam logic [19:0] BAUD_RST = 20'h00001;
    localparam int FIFO_DEPTH = 32;

    typedef enum logic [3:0] {
        FBL_WAIT_READY = 4'h0,
        FBL_WAIT_HIGH = 4'h1,
        FBL_WAIT_LOW = 4'h2,
        FBL_MEASURE = 4'h3,
        FBL_SEND_SYNC = 4'h4,
        FBL_WAIT_GO = 4'h5,
        FBL_ERASE = 4'h6,
        FBL_SEND_RES = 4'h7,
        FBL_LEN_HI = 4'h8,
        FBL_LEN_LO = 4'h9,
        FBL_DATA = 4'hA,
        FBL_SEND_DONE = 4'hB,
        FBL_BRANCH = 4'hC,
        FBL_HALT = 4'hD
    } fbl_state_t;

    typedef enum logic [1:0] {
        FBL_RX_IDLE = 2'h0,
        FBL_RX_START = 2'h1,
        FBL_RX_DATA = 2'h2,
        FBL_RX_STOP = 2'h3
    } fbl_rx_t;
endpackage

//--- src/fbl_boot.sv
`timescale 1ns/10ps
`default_nettype none

// byte buffer between the receiver and the sequencer
module fbl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire do_push = in_valid_i && in_ready_o;
    wire do_pop = out_valid_o && out_ready_i;

    // extra pointer bit tells full from empty
    assign in_ready_o = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (ce_i) begin
            if (do_push) begin
                mem[wr_ptr[AW-1:0]] <= in_data_i;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// Contract
// R01: 8N1 framing, no line inversion
// R02: time zero-byte low period, set divisor
// R03: measure only after 100 states
// R04: send one zero byte when matched
// R05: host checks zero, sends 0x55
// R06: erase if written; reply AA or FF
// R07: two length bytes, high first, echoed
// R08: echo each program byte, store sequentially
// R09: program lands in F780 to FEFF
// R10: send AA then branch to program
// R11: stop serial, keep divisor, tx high
// R12: host leaves boot via held reset
// R13: watchdog overflow ends boot like reset
// R14: host rate must suit clock
// R15: host programs 128-byte pages, FF fill
// R16: page start low byte 00 or 80
// R17: reprogram bit rule
// R18: additional-program bit rule
// R19: strobe pulse 30/10/200 us
// R20: at most 1000 program loops
// R21: watchdog about 6.6 ms while programming
// R22: verify by dummy FF write, word read
// R23: program mode needs unlock and setup first
// R24: straps stable four states before release
// R25: handshake receive error stops all replies
module fbl_boot import fbl_pkg::*; #(
    parameter int DIV_W = 20,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic watchdog_ovf_i,
    input wire logic boot_mode_i,
    input wire logic rx_pin_i,
    output logic tx_pin_level_o,
    output logic tx_pin_direction_o,
    output logic rx_on_flag_o,
    output logic tx_on_flag_o,
    output logic [DIV_W-1:0] baud_divisor_reg_o,
    input wire logic flash_blank_i,
    input wire logic erase_done_i,
    input wire logic erase_fail_i,
    output logic erase_req_o,
    output logic ram_we_o,
    output logic [15:0] ram_addr_o,
    output logic [7:0] ram_data_o,
    output logic branch_o,
    output logic [15:0] branch_addr_o,
    output logic boot_active_o,
    output logic boot_fail_o,
    input wire logic flash_write_unlock_i,
    input wire logic program_setup_flag_i,
    input wire logic write_strobe_i,
    output logic program_mode_o
);
    // watchdog overflow clears everything exactly as reset does
    wire rst = rst_i || watchdog_ovf_i; // R13

    fbl_state_t state;
    fbl_rx_t rx_st;
    logic boot_strap;
    logic [7:0] wait_cnt;
    logic [3:0] cnt9;
    logic [DIV_W-1:0] meas;
    logic [DIV_W-1:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_push;
    logic rx_err;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_left;
    logic [9:0] tx_sh;
    logic [15:0] len;
    logic [7:0] result;
    logic unlock_q;
    logic setup_q;

    wire tx_busy = tx_left != 4'h0;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire echo_state = (state == FBL_LEN_HI) || (state == FBL_LEN_LO) || (state == FBL_DATA);
    // echo needs a free transmitter, so the buffer drains no faster than tx
    wire pop = fifo_out_valid && ((echo_state && !tx_busy) || state == FBL_WAIT_GO);
    wire load_sync = state == FBL_SEND_SYNC && !tx_busy;
    wire load_res = state == FBL_SEND_RES && !tx_busy;
    wire load_done = state == FBL_SEND_DONE && !tx_busy;
    wire load_echo = pop && echo_state;
    wire tx_load = load_sync || load_res || load_done || load_echo;
    wire [7:0] tx_byte = load_sync ? BYTE_SYNC : load_res ? result : load_done ? BYTE_OK
                       : fifo_out_data;
    wire in_window = ram_addr_o <= RAM_HI;
    wire rx_tick = rx_cnt == '0;
    wire tx_tick = tx_cnt == '0;
    wire [DIV_W-1:0] div_m1 = baud_divisor_reg_o - 1'b1;

    fbl_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst),
        .ce_i(ce_i),
        .in_valid_i(rx_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rx_sh),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_out_data)
    );

    // receiver: 8N1, mid-bit sampling, line taken as is
    always_ff @(posedge clk_i) begin
        if (rst) begin
            rx_st <= FBL_RX_IDLE;
            rx_cnt <= '0;
            rx_bit <= 3'h0;
            rx_sh <= 8'h00;
            rx_push <= 1'b0;
            rx_err <= 1'b0;
        end else if (ce_i) begin
            rx_push <= 1'b0;
            rx_err <= 1'b0;
            rx_cnt <= rx_tick ? div_m1 : rx_cnt - 1'b1;
            case (rx_st)
                FBL_RX_IDLE: begin
                    rx_cnt <= baud_divisor_reg_o >> 1;
                    if (rx_on_flag_o && !rx_pin_i) rx_st <= FBL_RX_START; // R01
                end
                FBL_RX_START: if (rx_tick) begin
                    rx_bit <= 3'h0;
                    rx_st <= rx_pin_i ? FBL_RX_IDLE : FBL_RX_DATA;
                end
                FBL_RX_DATA: if (rx_tick) begin
                    rx_sh <= {rx_pin_i, rx_sh[7:1]}; // R01
                    rx_bit <= rx_bit + 1'b1;
                    if (rx_bit == 3'h7) rx_st <= FBL_RX_STOP;
                end
                FBL_RX_STOP: if (rx_tick) begin
                    // a full buffer counts as an overrun, the link cannot stall
                    rx_push <= rx_pin_i && fifo_in_ready;
                    rx_err <= !rx_pin_i || !fifo_in_ready;
                    rx_st <= FBL_RX_IDLE;
                end
                default: rx_st <= FBL_RX_IDLE;
            endcase
        end
    end

    // transmitter: start bit, eight data bits lsb first, stop bit
    always_ff @(posedge clk_i) begin
        if (rst) begin
            tx_left <= 4'h0;
            tx_sh <= 10'h3FF;
            tx_cnt <= '0;
            tx_pin_level_o <= 1'b1;
        end else if (ce_i) begin
            if (tx_load) begin
                tx_sh <= {1'b1, tx_byte, 1'b0}; // R01
                tx_left <= 4'(FRAME_BITS);
                tx_cnt <= div_m1;
                tx_pin_level_o <= 1'b0;
            end else if (tx_busy && tx_tick) begin
                tx_sh <= {1'b1, tx_sh[9:1]};
                tx_left <= tx_left - 1'b1;
                tx_cnt <= div_m1;
                tx_pin_level_o <= (tx_left == 4'h1) ? 1'b1 : tx_sh[1];
            end else if (tx_busy) begin
                tx_cnt <= tx_cnt - 1'b1;
            end
        end
    end

    // boot sequencer
    always_ff @(posedge clk_i) begin
        if (rst) begin
            state <= FBL_WAIT_READY;
            boot_strap <= 1'b0;
            wait_cnt <= 8'h00;
            cnt9 <= 4'h0;
            meas <= '0;
            baud_divisor_reg_o <= DIV_W'(BAUD_RST);
            rx_on_flag_o <= 1'b0;
            tx_on_flag_o <= 1'b0;
            tx_pin_direction_o <= 1'b0;
            erase_req_o <= 1'b0;
            ram_we_o <= 1'b0;
            ram_addr_o <= RAM_LO;
            ram_data_o <= 8'h00;
            branch_o <= 1'b0;
            branch_addr_o <= RAM_LO;
            boot_active_o <= 1'b0;
            boot_fail_o <= 1'b0;
            len <= 16'h0000;
            result <= BYTE_OK;
        end else if (ce_i) begin
            ram_we_o <= 1'b0;
            case (state)
                FBL_WAIT_READY: begin
                    // strap is caught on the first clock after release
                    if (wait_cnt == 8'h00) boot_strap <= boot_mode_i;
                    if (wait_cnt == 8'(READY_CYC - 1)) begin
                        state <= (boot_strap) ? FBL_WAIT_HIGH : FBL_HALT; // R03
                        boot_active_o <= boot_strap;
                        tx_pin_direction_o <= boot_strap;
                    end else begin
                        wait_cnt <= wait_cnt + 1'b1;
                    end
                end
                // a byte already under way at readiness is skipped
                FBL_WAIT_HIGH: if (rx_pin_i) state <= FBL_WAIT_LOW;
                FBL_WAIT_LOW: if (!rx_pin_i) begin
                    state <= FBL_MEASURE;
                    cnt9 <= 4'h1;
                    meas <= '0;
                end
                FBL_MEASURE: begin
                    if (rx_pin_i) begin
                        baud_divisor_reg_o <= (meas == '0) ? DIV_W'(BAUD_RST) : meas; // R02
                        rx_on_flag_o <= 1'b1;
                        tx_on_flag_o <= 1'b1;
                        state <= FBL_SEND_SYNC;
                    end else if (cnt9 == 4'(LOW_BITS - 1)) begin
                        // divide by nine on the fly: one divisor step per nine clocks
                        cnt9 <= 4'h0;
                        meas <= meas + 1'b1; // R02
                    end else begin
                        cnt9 <= cnt9 + 1'b1;
                    end
                end
                FBL_SEND_SYNC: if (load_sync) state <= FBL_WAIT_GO; // R04
                FBL_WAIT_GO: begin
                    if (rx_err) begin
                        state <= FBL_HALT; // R25
                        boot_fail_o <= 1'b1;
                    end else if (pop && fifo_out_data == BYTE_GO) begin
                        result <= BYTE_OK;
                        if (flash_blank_i) begin
                            state <= FBL_SEND_RES; // R06
                        end else begin
                            erase_req_o <= 1'b1; // R06
                            state <= FBL_ERASE;
                        end
                    end
                end
                FBL_ERASE: if (erase_done_i) begin
                    erase_req_o <= 1'b0;
                    result <= erase_fail_i ? BYTE_FAIL : BYTE_OK; // R06
                    state <= FBL_SEND_RES;
                end
                FBL_SEND_RES: if (load_res) begin
                    state <= (result == BYTE_FAIL) ? FBL_HALT : FBL_LEN_HI; // R06
                    boot_fail_o <= result == BYTE_FAIL;
                end
                FBL_LEN_HI: if (pop) begin
                    len[15:8] <= fifo_out_data; // R07
                    state <= FBL_LEN_LO;
                end
                FBL_LEN_LO: if (pop) begin
                    len[7:0] <= fifo_out_data; // R07
                    state <= ({len[15:8], fifo_out_data} == 16'h0000) ? FBL_SEND_DONE : FBL_DATA;
                end
                FBL_DATA: if (pop) begin
                    ram_we_o <= in_window; // R09
                    ram_data_o <= fifo_out_data; // R08
                    len <= len - 1'b1;
                    if (len == 16'h0001) state <= FBL_SEND_DONE;
                end
                FBL_SEND_DONE: if (load_done) state <= FBL_BRANCH; // R10
                FBL_BRANCH: if (!tx_busy && !branch_o) begin
                    rx_on_flag_o <= 1'b0; // R11
                    tx_on_flag_o <= 1'b0; // R11
                    branch_o <= 1'b1; // R10
                    boot_active_o <= 1'b0;
                end
                default: state <= FBL_HALT;
            endcase
            // address steps the clock after a store, so the pulse shows its own target
            if (ram_we_o) ram_addr_o <= ram_addr_o + 1'b1; // R08
        end
    end

    // program mode only if unlock and setup stood before the strobe
    always_ff @(posedge clk_i) begin
        if (rst) begin
            unlock_q <= 1'b0;
            setup_q <= 1'b0;
            program_mode_o <= 1'b0;
        end else if (ce_i) begin
            unlock_q <= flash_write_unlock_i;
            setup_q <= program_setup_flag_i && flash_write_unlock_i;
            program_mode_o <= write_strobe_i && unlock_q && setup_q; // R23
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst);

    a_ready_delay: assert property (state == FBL_WAIT_READY |-> !rx_on_flag_o) // R03
        else $error("receiver on before ready delay");
    a_sync_first: assert property ($rose(tx_busy) && state == FBL_WAIT_GO |-> tx_sh == 10'h200) // R04
        else $error("adjustment byte is not zero");
    a_go_erase: assert property ((state == FBL_WAIT_GO && pop && ce_i && fifo_out_data == BYTE_GO
        && !flash_blank_i) |=> erase_req_o) // R06
        else $error("erase not requested");
    a_fail_halt: assert property ((state == FBL_SEND_RES && load_res && ce_i
        && result == BYTE_FAIL) |=> state == FBL_HALT && boot_fail_o) // R06
        else $error("erase failure did not abort");
    a_ram_window: assert property (ram_we_o |-> ram_addr_o >= RAM_LO && ram_addr_o <= RAM_HI) // R09
        else $error("ram write outside window");
    a_echo_byte: assert property ((load_echo && ce_i) |=> tx_sh[8:1] == $past(fifo_out_data)) // R08
        else $error("echo differs from received byte");
    a_branch_idle: assert property ($rose(branch_o) |-> !rx_on_flag_o && !tx_on_flag_o
        && tx_pin_level_o && tx_pin_direction_o) // R11
        else $error("serial not stopped at branch");
    a_err_mute: assert property ((state == FBL_WAIT_GO && rx_err && ce_i) |=> state == FBL_HALT
        ##1 !tx_busy [*4]) // R25
        else $error("reply after handshake error");
    a_prog_mode: assert property (program_mode_o |-> $past(unlock_q) && $past(setup_q)) // R23
        else $error("program mode without unlock and setup");
    a_tx_idle: assert property (!tx_busy |-> tx_pin_level_o) // R01
        else $error("tx line low while idle");

    c_measured: cover property (state == FBL_MEASURE ##1 state == FBL_SEND_SYNC);
    c_erase: cover property (state == FBL_ERASE ##[1:50] state == FBL_SEND_RES);
    c_branch: cover property ($rose(branch_o));
    c_buffer_full: cover property (!fifo_in_ready);
endmodule

`default_nettype wire

//--- test/fbl_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// host computer on the far side of the boot serial link
module fbl_host_model #(
    parameter int BIT = 16
) (
    input wire logic clk_i,
    input wire logic tx_pin_level_i,
    input wire logic tx_pin_direction_i,
    output logic rx_pin_o
);
    logic line;
    logic [7:0] b;
    logic [8:0] rx_q[$];

    // a released tx pin reads high through the board pull-up
    assign line = tx_pin_direction_i ? tx_pin_level_i : 1'b1;

    initial rx_pin_o = 1'b1;

    localparam int MAX_LOOPS = 1000;
    localparam int WDT_US = 6600;

    // reprogram bit: 0 only for a wanted 0 that still reads back 1
    function automatic logic [7:0] reprog(input logic [7:0] want, input logic [7:0] vfy);
        return want | ~vfy;
    endfunction

    // additional-program bit: 0 only where reprogram and read-back are both 0
    function automatic logic [7:0] addprog(input logic [7:0] rep, input logic [7:0] vfy);
        return rep | vfy;
    endfunction

    // pulse length in us for write n; 0 once the loop limit is passed
    function automatic int pulse_us(input int n, input logic extra);
        if (n < 1 || n > MAX_LOOPS) return 0;
        if (n <= 6) return extra ? 10 : 30;
        return 200;
    endfunction

    // a pulse must end well inside the watchdog period of a programming run
    function automatic logic pulse_safe(input int us);
        return us < WDT_US;
    endfunction

    // page start: low byte 00 or 80
    function automatic logic [15:0] page_base(input logic [15:0] a);
        return {a[15:7], 7'h00};
    endfunction

    // slots past the data of a short page stay erased
    function automatic logic [7:0] page_fill(input int i, input int n, input logic [7:0] d);
        return (i < n) ? d : 8'hFF;
    endfunction

    // dummy FF write and word read both use the even address
    function automatic logic [15:0] verify_addr(input logic [15:0] a);
        return {a[15:1], 1'b0};
    endfunction

    task automatic idle;
        rx_pin_o <= 1'b1;
    endtask

    // start, eight data bits lsb first, stop; stop=0 forces a framing error
    task automatic send_byte(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_pin_o <= f[i];
            repeat (BIT) @(posedge clk_i);
        end
    endtask

    // zero byte, low stretched a little so sampling jitter cannot round down
    task automatic send_sync;
        rx_pin_o <= 1'b0;
        repeat (9 * BIT + 4) @(posedge clk_i);
        rx_pin_o <= 1'b1;
        repeat (BIT) @(posedge clk_i);
    endtask

    // mid-bit sampling of device frames; stop bit kept with the byte
    initial forever begin
        @(posedge clk_i);
        if (line === 1'b0) begin
            repeat (BIT / 2) @(posedge clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_i);
                b[i] = line;
            end
            repeat (BIT) @(posedge clk_i);
            rx_q.push_back({line, b});
        end
    end
endmodule

`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top import fbl_pkg::*; ();
    localparam int BIT = 16;
    logic clk_i, rst_i, wdg, boot_mode, blank, edone, efail, unlock, setup, strobe, rx_pin;
    logic ce;
    logic tx_lvl, tx_dir, rx_on, tx_on, ereq, ram_we, branch, bact, bfail, pmode;
    logic [19:0] divisor;
    logic [15:0] ram_addr, baddr;
    logic [7:0] ram_data;
    logic [7:0] seed = 8'h27;
    logic [23:0] ram_q[$];
    logic [7:0] prog[$];
    int mismatches = 0;
    int cmp_count = 0;
    int ecnt = 0;
    int erase_cnt = 0;

    fbl_boot u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .watchdog_ovf_i(wdg),
        .boot_mode_i(boot_mode), .rx_pin_i(rx_pin), .tx_pin_level_o(tx_lvl),
        .tx_pin_direction_o(tx_dir), .rx_on_flag_o(rx_on), .tx_on_flag_o(tx_on),
        .baud_divisor_reg_o(divisor), .flash_blank_i(blank), .erase_done_i(edone),
        .erase_fail_i(efail), .erase_req_o(ereq), .ram_we_o(ram_we), .ram_addr_o(ram_addr),
        .ram_data_o(ram_data), .branch_o(branch), .branch_addr_o(baddr),
        .boot_active_o(bact), .boot_fail_o(bfail), .flash_write_unlock_i(unlock),
        .program_setup_flag_i(setup), .write_strobe_i(strobe), .program_mode_o(pmode));

    fbl_host_model #(.BIT(BIT)) u_host (.clk_i(clk_i), .tx_pin_level_i(tx_lvl),
        .tx_pin_direction_i(tx_dir), .rx_pin_o(rx_pin));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // flash erase stand-in: done six cycles after the request, one-cycle pulse
    always @(posedge clk_i) begin
        ecnt <= (ereq === 1'b1 && edone !== 1'b1) ? ecnt + 1 : 0;
        edone <= (ecnt == 5);
        if (ereq === 1'b1) erase_cnt++;
        if (ram_we === 1'b1) ram_q.push_back({ram_addr, ram_data});
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic end_of_test;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // strap set while reset is held; watchdog overflow may stand in for reset
    task automatic do_reset(input int n, input logic wd, input logic mode);
        @(posedge clk_i);
        boot_mode <= mode;
        if (wd) wdg <= 1'b1; else rst_i <= 1'b1;
        u_host.idle();
        tick(n);
        rst_i <= 1'b0;
        wdg <= 1'b0;
        #1;
        check({tx_lvl, tx_dir, branch, ereq, pmode, bact}, 6'b100000);
        check(divisor, 32'h1);
        check(ram_addr, RAM_LO);
        erase_cnt = 0;
        ram_q.delete();
        u_host.rx_q.delete();
        tick(110);
    endtask

    // pops the next device byte, which must carry a good stop bit
    task automatic expect_byte(input logic [7:0] exp);
        int n;
        n = 0;
        while (u_host.rx_q.size() == 0 && n < 60 * BIT) begin
            @(posedge clk_i);
            n++;
        end
        if (u_host.rx_q.size() == 0) check(32'h0, {1'b1, exp});
        else check(u_host.rx_q.pop_front(), {1'b1, exp});
    endtask

    task automatic sync_go;
        u_host.send_sync();
        expect_byte(BYTE_SYNC);
        check(divisor, BIT);
        check({rx_on, tx_on, tx_dir}, 3'b111);
    endtask

    // nothing may come back, even after the host keeps talking
    task automatic silence;
        u_host.send_byte(8'h01, 1'b1);
        tick(30 * BIT);
        check(32'(u_host.rx_q.size()), 0);
        check(bfail, 1'b1);
    endtask

    // length high first, random program bytes sent back to back, then branch
    task automatic load(input int n);
        int w;
        prog.delete();
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            prog.push_back(seed);
        end
        u_host.send_byte(8'(n >> 8), 1'b1);
        u_host.send_byte(8'(n), 1'b1);
        foreach (prog[i]) u_host.send_byte(prog[i], 1'b1);
        expect_byte(8'(n >> 8));
        expect_byte(8'(n));
        foreach (prog[i]) expect_byte(prog[i]);
        expect_byte(BYTE_OK);
        w = 0;
        while (branch !== 1'b1 && w < 4 * BIT) begin
            @(posedge clk_i);
            w++;
        end
        #1;
        check({branch, bact, baddr}, {2'b10, RAM_LO});
        check({rx_on, tx_on, tx_lvl, tx_dir}, 4'b0011);
        check(divisor, BIT);
        check(32'(ram_q.size()), n);
        foreach (prog[i]) check(ram_q[i], {RAM_LO + 16'(i), prog[i]});
    endtask

    initial begin
        {rst_i, wdg, boot_mode, blank, efail, unlock, setup, strobe, edone} = 9'h1;
        rst_i = 1'b1;
        ce = 1'b1;
        // written flash, erase passes, five program bytes
        do_reset(10, 1'b0, 1'b1);
        sync_go();
        u_host.send_byte(BYTE_GO, 1'b1);
        expect_byte(BYTE_OK);
        check(32'(erase_cnt != 0), 1);
        load(5);
        // watchdog restart, blank flash skips erase, empty program
        blank <= 1'b1;
        do_reset(20, 1'b1, 1'b1);
        sync_go();
        u_host.send_byte(BYTE_GO, 1'b1);
        expect_byte(BYTE_OK);
        check(32'(erase_cnt), 0);
        load(0);
        // erase failure answers FF and stops
        blank <= 1'b0;
        efail <= 1'b1;
        do_reset(20, 1'b0, 1'b1);
        sync_go();
        u_host.send_byte(BYTE_GO, 1'b1);
        expect_byte(BYTE_FAIL);
        silence();
        // framing error while waiting for the go byte
        efail <= 1'b0;
        do_reset(20, 1'b0, 1'b1);
        sync_go();
        u_host.send_byte(BYTE_GO, 1'b0);
        u_host.idle();
        silence();
        // user strap: program mode gating needs unlock and setup first
        do_reset(20, 1'b0, 1'b0);
        unlock <= 1'b1;
        strobe <= 1'b1;
        tick(3);
        #1;
        check(pmode, 1'b0);
        tick(1);
        strobe <= 1'b0;
        setup <= 1'b1;
        tick(2);
        strobe <= 1'b1;
        tick(2);
        #1;
        check(pmode, 1'b1);
        tick(1);
        // clock enable low freezes program mode although the flags drop
        {ce, unlock, setup} <= 3'b000;
        tick(3);
        #1;
        check(pmode, 1'b1);
        tick(1);
        ce <= 1'b1;
        tick(3);
        #1;
        check(pmode, 1'b0);
        // host-side programming arithmetic held by the partner model
        check(u_host.reprog(8'h33, 8'h55), 8'hBB);
        check(u_host.addprog(8'h33, 8'h55), 8'h77);
        check(u_host.pulse_us(6, 1'b0), 30);
        check(u_host.pulse_us(1, 1'b1), 10);
        check(u_host.pulse_us(1000, 1'b0), 200);
        check(u_host.pulse_us(1001, 1'b0), 0);
        check(u_host.pulse_safe(200), 1);
        check(u_host.page_base(16'h12C3), 16'h1280);
        check(u_host.page_fill(100, 5, 8'h12), 8'hFF);
        check(u_host.verify_addr(16'h1283), 16'h1282);
        end_of_test();
    end

    // hang guard, well beyond the few thousand cycles the runs need
    initial begin
        tick(30000);
        mismatches++;
        end_of_test();
    end
endmodule

`default_nettype wire
